// ---- design/ppr_phy_paged_register_map.sv ----
/*
 * Register map of a three-port serial-bus physical layer: eight fixed base registers and
 * an eight-address window steered by the page and port held in base register seven.
 * Assumes a register master on a plain strobe port and a core that supplies status
 * and bus reset pulses synchronous to clk.
 */
// Operation
// R1 - Sixteen registers decoded from four address bits
// R2 - Addresses zero to seven hold fixed layout
// R3 - Addresses eight to fifteen follow selected page
// R4 - Page comes from register seven's field
// R5 - Base registers ignore the selected page
// R6 - Reserved registers and fields read zero
// R7 - Pages two to six read as zero
// R8 - Contender pin is input only during reset
// R9 - Contender loads from pin, bus reset keeps
// R10 - Read-only writes ignored; bit zero is MSB
`timescale 1ns/10ps
`default_nettype none

module ppr_phy_paged_register_map import ppr_pkg::*; #(
	parameter int NUM_PORTS = PPR_NUM_PORTS_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [5:0] node_number,
	input wire logic root_in,
	input wire logic cable_power_in,
	input wire logic bus_reset,
	input wire logic cfg_gap_wr,
	input wire logic [5:0] cfg_gap_val,
	input wire logic link_on_req,
	input wire logic contender_linkon_pin_in,
	output logic contender_linkon_pin_out,
	output logic contender_linkon_pin_oe,
	output logic root_holdoff,
	output logic ibr_req,
	output logic [5:0] gap_count,
	output logic link_active,
	output logic contender,
	output logic [2:0] power_class,
	output logic [7:0] feature_en,
	output logic [2:0] page_select,
	output logic [3:0] port_select
);

	localparam int BANK_W = 4;
	localparam int BANKS = NUM_PORTS + 2;

	// The port field is four bits wide and two bank codes sit above the ports.
	generate
		if (NUM_PORTS < 1 || NUM_PORTS > 13) begin : g_bad_ports
			$error("NUM_PORTS must lie between 1 and 13");
		end
	endgenerate

	typedef struct packed {
		logic [7:0] rdata;
		logic rhb;
		logic ibr;
		logic [5:0] gap;
		ppr_gap_state_t gap_st;
		logic link;
		logic cont;
		logic [2:0] pwr;
		logic [7:0] feat;
		logic [2:0] page;
		logic [3:0] port;
		logic pin_oe;
		logic pin_out;
	} ppr_state_t;

	ppr_state_t st_reg;
	ppr_state_t st_next;
	logic [7:0] base_word;
	logic [BANK_W:0] hit;
	logic store_wr;
	logic [7:0] store_rdata;
	logic strap_level;
	logic strap_load;
	logic paged_acc;
	logic gap_wr_sw;

	// Maps page and port to a storage bank; the top bit says the page is backed.
	function automatic logic [BANK_W:0] bank_lookup(input logic [2:0] page, input logic [3:0] port);
		logic [BANK_W:0] r;
		r = '0;
		if (page == PPR_PAGE_PORT_STATUS && port < 4'(NUM_PORTS)) begin
			r = {1'b1, port};
		end else if (page == PPR_PAGE_VENDOR) begin
			r = {1'b1, 4'(NUM_PORTS)};
		end else if (page == PPR_PAGE_EXT) begin
			r = {1'b1, 4'(NUM_PORTS + 1)};
		end
		return r;
	endfunction : bank_lookup

	// The strap is caught by a clocked flop; an async-reset flop may only take constants.
	ppr_strap_capture u_strap (
		.clk(clk),
		.rst_n(rst_n),
		.pin_level(contender_linkon_pin_in),
		.strap_level(strap_level),
		.strap_load(strap_load)
	);

	// Paged decode: the upper address half is steered by the stored page and port.
	assign paged_acc = reg_addr[PPR_PAGED_BIT]; // R1
	assign hit = bank_lookup(st_reg.page, st_reg.port); // R3 R4
	assign store_wr = reg_wr && paged_acc && hit[BANK_W]; // R7
	assign gap_wr_sw = reg_wr && (reg_addr == PPR_ADDR_GAP);

	ppr_page_store #(
		.BANKS(BANKS),
		.BANK_W(BANK_W)
	) u_store (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(store_wr),
		.bank(hit[BANK_W-1:0]),
		.idx(reg_addr[2:0]),
		.wdata(reg_wdata),
		.rdata(store_rdata)
	);

	// Base register read mux; it never looks at the page, and reserved bits stay zero.
	always_comb begin
		base_word = 8'h00;
		unique case (reg_addr[2:0]) // R2 R5 R6
			PPR_ADDR_NODE[2:0]: begin
				base_word[PPR_NODE_MSB:PPR_NODE_LSB] = node_number;
				base_word[PPR_ROOT_BIT] = root_in;
				base_word[PPR_CPS_BIT] = cable_power_in;
			end
			PPR_ADDR_GAP[2:0]: begin
				base_word[PPR_RHB_BIT] = st_reg.rhb;
				base_word[PPR_IBR_BIT] = st_reg.ibr;
				base_word[PPR_GAP_MSB:0] = st_reg.gap;
			end
			PPR_ADDR_PORTS[2:0]: begin
				base_word[7:PPR_EXT_LSB] = PPR_EXT_VAL;
				base_word[PPR_NPORT_MSB:0] = 4'(NUM_PORTS);
			end
			PPR_ADDR_SPEED[2:0]: begin
				base_word[7:PPR_SPEED_LSB] = PPR_SPEED_VAL;
				base_word[PPR_DELAY_MSB:0] = PPR_DELAY_VAL;
			end
			PPR_ADDR_LINK[2:0]: begin
				base_word[PPR_LINK_BIT] = st_reg.link;
				base_word[PPR_CONT_BIT] = st_reg.cont;
				base_word[PPR_CONT_BIT-1:PPR_JIT_LSB] = PPR_JITTER_VAL;
				base_word[PPR_PWR_MSB:0] = st_reg.pwr;
			end
			PPR_ADDR_FEAT[2:0]: begin
				base_word = st_reg.feat;
			end
			PPR_ADDR_RSVD6[2:0]: begin
				base_word = 8'h00;
			end
			PPR_ADDR_PAGE[2:0]: begin
				base_word[7:PPR_PAGESEL_LSB] = st_reg.page;
				base_word[PPR_PORTSEL_MSB:0] = st_reg.port;
			end
		endcase
	end

	// Next-state logic for every register and the pin driver.
	always_comb begin
		st_next = st_reg;
		// Read data stand for one cycle only and fall back to zero otherwise.
		st_next.rdata = 8'h00;
		if (reg_rd) begin
			if (paged_acc) begin
				st_next.rdata = hit[BANK_W] ? store_rdata : 8'h00; // R3 R7
			end else begin
				st_next.rdata = base_word; // R5
			end
		end
		// The pin is released to the strap only while reset is low.
		st_next.pin_oe = 1'b1; // R8
		st_next.pin_out = link_on_req;
		// Hardware reset loads the contender from the strap once, at release.
		if (strap_load) begin
			st_next.cont = strap_level; // R9
		end
		// A bus reset clears the initiate request; a same-cycle write setting it wins below.
		if (bus_reset) begin
			st_next.ibr = 1'b0;
			unique case (st_reg.gap_st)
				PPR_GAP_FRESH: begin
					st_next.gap_st = PPR_GAP_ONE;
				end
				PPR_GAP_ONE: begin
					st_next.gap = PPR_GAP_RST;
				end
			endcase
		end
		// A configuration packet counts as a gap write.
		if (cfg_gap_wr) begin
			st_next.gap = cfg_gap_val;
			st_next.gap_st = PPR_GAP_FRESH;
		end
		// Software writes; only writable fields are taken, all else is dropped.
		if (reg_wr && !paged_acc) begin
			unique case (reg_addr[2:0]) // R10
				PPR_ADDR_GAP[2:0]: begin
					st_next.rhb = reg_wdata[PPR_RHB_BIT];
					st_next.ibr = reg_wdata[PPR_IBR_BIT] | (st_reg.ibr & ~bus_reset);
					st_next.gap = reg_wdata[PPR_GAP_MSB:0];
					st_next.gap_st = PPR_GAP_FRESH;
				end
				PPR_ADDR_LINK[2:0]: begin
					st_next.link = reg_wdata[PPR_LINK_BIT];
					st_next.cont = reg_wdata[PPR_CONT_BIT];
					st_next.pwr = reg_wdata[PPR_PWR_MSB:0];
				end
				PPR_ADDR_FEAT[2:0]: begin
					st_next.feat = reg_wdata;
				end
				PPR_ADDR_PAGE[2:0]: begin
					st_next.page = reg_wdata[7:PPR_PAGESEL_LSB]; // R4
					st_next.port = reg_wdata[PPR_PORTSEL_MSB:0];
				end
				PPR_ADDR_NODE[2:0], PPR_ADDR_PORTS[2:0], PPR_ADDR_SPEED[2:0],
				PPR_ADDR_RSVD6[2:0]: begin
					// Read-only and reserved registers keep their state.
				end
			endcase
		end
	end

	// State flops; the pin enable resets low so the strap can be sampled.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.rdata <= 8'h00;
			st_reg.rhb <= PPR_RHB_RST;
			st_reg.ibr <= PPR_IBR_RST;
			st_reg.gap <= PPR_GAP_RST;
			st_reg.gap_st <= PPR_GAP_FRESH;
			st_reg.link <= PPR_LINK_RST;
			st_reg.cont <= 1'b0;
			st_reg.pwr <= PPR_PWR_RST;
			st_reg.feat <= PPR_FEAT_RST;
			st_reg.page <= PPR_PAGE_RST;
			st_reg.port <= PPR_PORT_RST;
			st_reg.pin_oe <= 1'b0; // R8
			st_reg.pin_out <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Every output is a flop of the state record.
	assign reg_rdata = st_reg.rdata;
	assign contender_linkon_pin_out = st_reg.pin_out;
	assign contender_linkon_pin_oe = st_reg.pin_oe;
	assign root_holdoff = st_reg.rhb;
	assign ibr_req = st_reg.ibr;
	assign gap_count = st_reg.gap;
	assign link_active = st_reg.link;
	assign contender = st_reg.cont;
	assign power_class = st_reg.pwr;
	assign feature_en = st_reg.feat;
	assign page_select = st_reg.page;
	assign port_select = st_reg.port;

	// Checks on the register map; all run on clk and are off during reset.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// A paged write followed at once by a read of the same place on an unchanged page.
	sequence s_paged_write;
		reg_wr && paged_acc && hit[BANK_W];
	endsequence

	sequence s_paged_readback;
		reg_rd && (reg_addr == $past(reg_addr)) && $stable(st_reg.page) && $stable(st_reg.port);
	endsequence

	// Two bus resets with no gap write between them.
	sequence s_two_resets;
		bus_reset && !cfg_gap_wr && !gap_wr_sw ##1 (!bus_reset && !cfg_gap_wr && !gap_wr_sw)[*2]
			##1 bus_reset && !cfg_gap_wr && !gap_wr_sw;
	endsequence

	a_rdata_one_cycle: assert property ( // R1
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data present without a read strobe");

	a_fixed_ports_word: assert property ( // R2
		reg_rd && reg_addr == PPR_ADDR_PORTS |=> reg_rdata == {PPR_EXT_VAL, 1'b0, 4'(NUM_PORTS)})
		else $error("port count register wrong");

	a_paged_readback: assert property ( // R3
		s_paged_write ##1 s_paged_readback |=> reg_rdata == $past(reg_wdata, 2))
		else $error("paged write not read back");

	a_page_steer_field: assert property ( // R4
		reg_wr && reg_addr == PPR_ADDR_PAGE |=> page_select == $past(reg_wdata[7:5])
			&& port_select == $past(reg_wdata[3:0]))
		else $error("page select not taken from register seven");

	a_base_page_free: assert property ( // R5
		reg_rd && reg_addr == PPR_ADDR_GAP
			|=> reg_rdata == {$past(root_holdoff), $past(ibr_req), $past(gap_count)})
		else $error("base register read depends on page");

	a_reserved_reads_zero: assert property ( // R6
		reg_rd && reg_addr == PPR_ADDR_RSVD6 |=> reg_rdata == 8'h00)
		else $error("reserved register read nonzero");

	a_rsvd_page_zero: assert property ( // R7
		reg_rd && paged_acc && ppr_page_reserved(page_select) |=> reg_rdata == 8'h00)
		else $error("reserved page read nonzero");

	a_pin_driven_after: assert property ( // R8
		rst_n |=> contender_linkon_pin_oe)
		else $error("contender pin not driven after reset");

	a_strap_loads_bit: assert property ( // R9
		rst_n && strap_load && !(reg_wr && reg_addr == PPR_ADDR_LINK)
			|=> contender == $past(strap_level))
		else $error("contender bit not loaded from strap");

	a_bus_reset_keeps: assert property ( // R9
		bus_reset && !strap_load && !(reg_wr && reg_addr == PPR_ADDR_LINK)
			&& !(reg_wr && reg_addr == PPR_ADDR_GAP)
			|=> $stable(contender) && $stable(link_active) && $stable(root_holdoff))
		else $error("bus reset changed a sticky bit");

	a_ro_write_ignored: assert property ( // R10
		reg_wr && (reg_addr == PPR_ADDR_SPEED || reg_addr == PPR_ADDR_RSVD6) && !bus_reset
			&& !cfg_gap_wr && !strap_load
			|=> $stable(gap_count) && $stable(feature_en) && $stable(contender)
			&& $stable(page_select) && $stable(ibr_req))
		else $error("write to read-only register had an effect");

	a_gap_double_reset: assert property (
		s_two_resets |=> gap_count == PPR_GAP_RST)
		else $error("gap count not restored after two bus resets");

endmodule : ppr_phy_paged_register_map

`default_nettype wire

// ---- design/ppr_pkg.sv ----
/*
 * Shared constants of the paged register map: register offsets, field positions, fixed
 * field values, reset values, page numbers, the gap-count tracking state and page decoding.
 * Assumes it is compiled before every other design file of the block.
 */
package ppr_pkg;

	// Register offsets; the upper eight addresses are the paged window.
	localparam logic [3:0] PPR_ADDR_NODE = 4'h0;
	localparam logic [3:0] PPR_ADDR_GAP = 4'h1;
	localparam logic [3:0] PPR_ADDR_PORTS = 4'h2;
	localparam logic [3:0] PPR_ADDR_SPEED = 4'h3;
	localparam logic [3:0] PPR_ADDR_LINK = 4'h4;
	localparam logic [3:0] PPR_ADDR_FEAT = 4'h5;
	localparam logic [3:0] PPR_ADDR_RSVD6 = 4'h6;
	localparam logic [3:0] PPR_ADDR_PAGE = 4'h7;
	localparam int PPR_PAGED_BIT = 3;

	// Field positions in Verilog order; bit position zero of a register is bit 7 here.
	localparam int PPR_NODE_MSB = 7;
	localparam int PPR_NODE_LSB = 2;
	localparam int PPR_ROOT_BIT = 1;
	localparam int PPR_CPS_BIT = 0;
	localparam int PPR_RHB_BIT = 7;
	localparam int PPR_IBR_BIT = 6;
	localparam int PPR_GAP_MSB = 5;
	localparam int PPR_EXT_LSB = 5;
	localparam int PPR_NPORT_MSB = 3;
	localparam int PPR_SPEED_LSB = 5;
	localparam int PPR_DELAY_MSB = 3;
	localparam int PPR_LINK_BIT = 7;
	localparam int PPR_CONT_BIT = 6;
	localparam int PPR_JIT_LSB = 3;
	localparam int PPR_PWR_MSB = 2;
	localparam int PPR_PAGESEL_LSB = 5;
	localparam int PPR_PORTSEL_MSB = 3;

	// Fixed read-only field values.
	localparam logic [2:0] PPR_EXT_VAL = 3'h7;
	localparam logic [2:0] PPR_SPEED_VAL = 3'h2;
	localparam logic [3:0] PPR_DELAY_VAL = 4'h0;
	localparam logic [2:0] PPR_JITTER_VAL = 3'h0;
	localparam int PPR_NUM_PORTS_DEF = 3;

	// Reset values.
	localparam logic [5:0] PPR_GAP_RST = 6'h3F;
	localparam logic PPR_LINK_RST = 1'b1;
	localparam logic PPR_RHB_RST = 1'b0;
	localparam logic PPR_IBR_RST = 1'b0;
	localparam logic [2:0] PPR_PWR_RST = 3'h0;
	localparam logic [7:0] PPR_FEAT_RST = 8'h00;
	localparam logic [2:0] PPR_PAGE_RST = 3'h0;
	localparam logic [3:0] PPR_PORT_RST = 4'h0;

	// Pages that are backed by storage; every other page is reserved.
	localparam logic [2:0] PPR_PAGE_PORT_STATUS = 3'h0;
	localparam logic [2:0] PPR_PAGE_VENDOR = 3'h1;
	localparam logic [2:0] PPR_PAGE_EXT = 3'h7;

	// Bus resets seen since the gap count was last written.
	typedef enum logic [0:0] {
		PPR_GAP_FRESH = 1'b0,
		PPR_GAP_ONE = 1'b1
	} ppr_gap_state_t;

	// True for pages two through six.
	function automatic logic ppr_page_reserved(input logic [2:0] page);
		return (page != PPR_PAGE_PORT_STATUS) && (page != PPR_PAGE_VENDOR) && (page != PPR_PAGE_EXT);
	endfunction : ppr_page_reserved

endpackage : ppr_pkg

// ---- design/ppr_strap_capture.sv ----
/*
 * Captures the contender strap level while reset is held and holds a load pulse high through
 * reset, dropping it on the first clock edge after reset is released.
 * Assumes the pin is not driven by this device while reset is low.
 */
`timescale 1ns/10ps
`default_nettype none

module ppr_strap_capture (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin_level,
	output logic strap_level,
	output logic strap_load
);

	logic sample_reg;
	logic load_reg;

	// No reset here on purpose: the flop must keep sampling the pin while reset is low.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_reg <= pin_level;
		end
	end

	// Load is held high through reset and drops after the first edge past release.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			load_reg <= 1'b1;
		end else begin
			load_reg <= 1'b0;
		end
	end

	assign strap_level = sample_reg;
	assign strap_load = load_reg;

endmodule : ppr_strap_capture

`default_nettype wire

// ---- design/ppr_page_store.sv ----
/*
 * Byte storage behind the paged window: one bank of eight bytes per port of the port-status page, plus one each for the vendor and extended pages.
 * Assumes the caller decides which bank an access reaches and masks reserved pages.
 */
`timescale 1ns/10ps
`default_nettype none

module ppr_page_store #(
	parameter int BANKS = 5,
	parameter int BANK_W = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [BANK_W-1:0] bank,
	input wire logic [2:0] idx,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);

	typedef struct packed {
		logic [BANKS*8-1:0][7:0] mem;
	} ppr_store_t;

	ppr_store_t st_reg;
	ppr_store_t st_next;
	logic [BANK_W+2:0] sel;

	// Flat index of the addressed byte.
	assign sel = {bank, idx};

	// Write the addressed byte.
	always_comb begin
		st_next = st_reg;
		if (wr_en && (int'(sel) < BANKS * 8)) begin
			st_next.mem[sel] = wdata;
		end
	end

	// Storage flops.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Out-of-range banks read as zero.
	assign rdata = (int'(sel) < BANKS * 8) ? st_reg.mem[sel] : 8'h00;

endmodule : ppr_page_store

`default_nettype wire

// ---- verif/ppr_link_ctrl.sv ----
/*
 * Link-layer controller model: register master tasks on the strobe port, and the
 * external strap that holds the contender pin while the device is in reset.
 * Assumes the bench calls the tasks from one process, one access at a time.
 */
`timescale 1ns/10ps
`default_nettype none

module ppr_link_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strap,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_level,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// The strap reaches the wire only in reset; an undriven wire flips so a late sample shows.
	assign pin_level = pin_oe ? pin_out : (!rst_n ? strap : ~pin_out);

	// Idle bus before the first access.
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One-cycle write strobe; the device takes it at the next edge.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so both that cycle and the next are kept.
	task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [7:0] after);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		@(posedge clk);
		#1;
		after = reg_rdata;
	endtask : rd

	// Write then read the same place in the next cycle, with no idle cycle between.
	task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		q = reg_rdata;
	endtask : wr_rd
endmodule : ppr_link_ctrl
`default_nettype wire

// ---- verif/ppr_phy_paged_register_map_bench.sv ----
/*
 * Self-checking bench of the paged register map: a register model in integers is
 * compared with every read, and with the register outputs after every reset and every random operation.
 * Assumes the link controller model in ppr_link_ctrl.sv and the design package.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end

module ppr_phy_paged_register_map_bench import ppr_pkg::*;;
	localparam int NP = 3;
	logic clk, rst_n, strap, bus_reset, cfg_gap_wr, link_on_req, root_in, cable_power_in;
	logic [5:0] node_number, cfg_gap_val, gap_count;
	logic [3:0] reg_addr, port_select;
	logic [7:0] reg_wdata, reg_rdata, feature_en, got, aft;
	logic reg_wr, reg_rd, pin_level, pin_out, pin_oe, root_holdoff, ibr_req;
	logic link_active, contender;
	logic [2:0] power_class, page_select;
	// Model state.
	logic rhb, ibr, link, cont;
	logic [5:0] gap;
	logic [2:0] pwr, page;
	logic [3:0] port;
	logic [7:0] feat;
	int brs, failures, num_checks;
	int mem[int];

	ppr_phy_paged_register_map #(.NUM_PORTS(NP)) dut (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .node_number(node_number), .root_in(root_in),
		.cable_power_in(cable_power_in), .bus_reset(bus_reset), .cfg_gap_wr(cfg_gap_wr),
		.cfg_gap_val(cfg_gap_val), .link_on_req(link_on_req),
		.contender_linkon_pin_in(pin_level), .contender_linkon_pin_out(pin_out),
		.contender_linkon_pin_oe(pin_oe), .root_holdoff(root_holdoff), .ibr_req(ibr_req),
		.gap_count(gap_count), .link_active(link_active), .contender(contender),
		.power_class(power_class), .feature_en(feature_en), .page_select(page_select),
		.port_select(port_select));

	ppr_link_ctrl u_lc (.clk(clk), .rst_n(rst_n), .strap(strap), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_level(pin_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Storage index of a paged address, or -1 where the location is reserved.
	function automatic int key(input logic [3:0] a);
		if (!a[3] || !(page == 3'h1 || page == 3'h7 || (page == 3'h0 && int'(port) < NP))) begin
			return -1;
		end
		return int'(page) * 256 + (page == 3'h0 ? int'(port) : 0) * 8 + int'(a[2:0]);
	endfunction : key

	// Expected read value; reserved fields and places are zero.
	function automatic logic [7:0] exp_rd(input logic [3:0] a);
		int k;
		k = key(a);
		case (a)
			4'h0: return {node_number, root_in, cable_power_in};
			4'h1: return {rhb, ibr, gap};
			4'h2: return {PPR_EXT_VAL, 1'b0, 4'(NP)};
			4'h3: return {PPR_SPEED_VAL, 1'b0, PPR_DELAY_VAL};
			4'h4: return {link, cont, 3'h0, pwr};
			4'h5: return feat;
			4'h7: return {page, 1'b0, port};
			default: return (k >= 0 && mem.exists(k)) ? 8'(mem[k]) : 8'h00;
		endcase
	endfunction : exp_rd

	// Model of a register write; read-only and reserved places keep nothing.
	function automatic void apply_wr(input logic [3:0] a, input logic [7:0] d);
		int k;
		k = key(a);
		case (a)
			4'h1: begin
				rhb = d[7];
				ibr = ibr | d[6];
				gap = d[5:0];
				brs = 0;
			end
			4'h4: begin
				link = d[7];
				cont = d[6];
				pwr = d[2:0];
			end
			4'h5: feat = d;
			4'h7: {page, port} = {d[7:5], d[3:0]};
			default: if (k >= 0) mem[k] = d;
		endcase
	endfunction : apply_wr

	task automatic check_outs;
		@(posedge clk);
		#1;
		`CHK({root_holdoff, ibr_req, gap_count}, {rhb, ibr, gap})
		`CHK({link_active, contender, power_class}, {link, cont, pwr})
		`CHK({page_select, port_select, feature_en}, {page, port, feat})
		`CHK({pin_oe, pin_out}, {1'b1, link_on_req})
	endtask : check_outs

	// Reset with a given strap level, checking the pin is released meanwhile.
	task automatic do_reset(input logic s);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= s;
		repeat (4) @(posedge clk);
		#1;
		`CHK({pin_oe, reg_rdata}, 9'h000)
		@(posedge clk);
		rst_n <= 1'b1;
		{rhb, ibr, gap, brs, link, cont, pwr, feat, page, port} = {2'b00, 6'h3F, 32'd0, 1'b1, s, 18'h0};
		mem.delete();
		@(posedge clk);
		check_outs();
	endtask : do_reset

	// Every page once: its window, then a base register that must not follow it.
	task automatic page_sweep;
		for (int p = 0; p < 8; p++) begin
			u_lc.wr(4'h7, {3'(p), 5'h00});
			apply_wr(4'h7, {3'(p), 5'h00});
			u_lc.wr(4'(8 + p), 8'hA5 ^ 8'(p));
			apply_wr(4'(8 + p), 8'hA5 ^ 8'(p));
			u_lc.rd(4'(8 + p), got, aft);
			`CHK(got, exp_rd(4'(8 + p)))
			u_lc.wr_rd(4'(8 + p), 8'h5A ^ 8'(p), got);
			apply_wr(4'(8 + p), 8'h5A ^ 8'(p));
			`CHK(got, exp_rd(4'(8 + p)))
			u_lc.rd(4'h5, got, aft);
			`CHK(got, feat)
		end
	endtask : page_sweep

	task automatic run_ops(input int n);
		int op;
		logic [3:0] a;
		logic [7:0] d;
		for (int i = 0; i < n; i++) begin
			op = $urandom_range(0, 9);
			a = (op == 0) ? 4'h7 : (op == 4) ? {1'b1, 3'($urandom)} : 4'($urandom);
			d = 8'($urandom);
			@(posedge clk);
			{link_on_req, root_in, cable_power_in, node_number} <= 9'($urandom);
			if (op < 4) begin
				u_lc.wr(a, d);
				apply_wr(a, d);
			end else if (op < 8) begin
				u_lc.rd(a, got, aft);
				`CHK(got, exp_rd(a))
				`CHK(aft, 8'h00)
			end else begin
				cfg_gap_val <= d[5:0];
				if (op == 8) bus_reset <= 1'b1;
				else cfg_gap_wr <= 1'b1;
				@(posedge clk);
				{bus_reset, cfg_gap_wr} <= 2'b00;
				if (op == 9) {gap, brs} = {d[5:0], 32'd0};
				else begin
					ibr = 1'b0;
					gap = (brs != 0) ? 6'h3F : gap;
					brs = 1;
				end
			end
			check_outs();
		end
	endtask : run_ops

	task automatic results;
		if (failures == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	// Main sequence; the second reset lands in mid-run with the opposite strap.
	initial begin
		{rst_n, strap, bus_reset, cfg_gap_wr, link_on_req, root_in, cable_power_in} = 7'h00;
		{node_number, cfg_gap_val} = 12'h000;
		{failures, num_checks} = {32'd0, 32'd0};
		void'($urandom(32'hFCE9));
		do_reset(1'b0);
		page_sweep();
		run_ops(400);
		do_reset(1'b1);
		run_ops(400);
		results();
	end

	// Cuts a hang short; the run needs far fewer cycles than this.
	initial begin
		#1000000;
		failures++;
		results();
	end
endmodule : ppr_phy_paged_register_map_bench
`default_nettype wire
